// >>> backplane_model.sv
// backplane highway model: bit clocks, receive data, capture of outputs
`timescale 1ns/10ps
`default_nettype none

module backplane_model
  import pcm_pkg::*;
(
  // bench controls
  input wire logic core_clk,
  input wire logic run,
  input wire logic dbl_stop,
  // toward the block
  output logic bit_clock_2m,
  output logic double_rate_clock,
  output logic backplane_rx_data,
  output logic [E1_BUSES-1:0] e1_bus_rx,
  // from the block
  input wire logic backplane_tx_data,
  input wire logic backplane_tx_oe,
  input wire logic frame_sync_8k,
  input wire logic [E1_BUSES-1:0] e1_bus_tx
);
  logic [2:0] ph; // core cycles into the bit period
  logic [7:0] pos; // bits since the last frame sync
  logic txb [256]; // one frame of captured line bits
  logic oeb [256]; // one frame of captured enable bits
  logic [3:0] e1b [256]; // one frame of captured e1 bus bits
  int frames; // frame syncs seen

  initial begin
    ph = 3'h0;
    pos = 8'h00;
    frames = 0;
    bit_clock_2m = 1'b0;
    double_rate_clock = 1'b0;
    backplane_rx_data = 1'b0;
    e1_bus_rx = 4'h0;
  end

  // bit clock of 8 core cycles, free running; double-rate clock of 4
  always @(posedge core_clk) begin : drive
    logic [7:0] cur;
    logic [7:0] nxt;
    logic [7:0] b;
    if (run) begin
      ph <= ph + 3'h1;
      // the double-rate clock stands still only when a loss is commanded
      if (!dbl_stop && ph[0]) double_rate_clock <= ~double_rate_clock;
      if (ph == 3'h4) bit_clock_2m <= 1'b1;
      if (ph == 3'h0) begin
        bit_clock_2m <= 1'b0;
        // outputs have been settled since mid bit, so sample them here
        cur = frame_sync_8k ? 8'h00 : pos;
        nxt = cur + 8'h01;
        txb[cur] <= backplane_tx_data;
        oeb[cur] <= backplane_tx_oe;
        e1b[cur] <= e1_bus_tx;
        pos <= nxt;
        if (frame_sync_8k) frames <= frames + 1;
        // next bit, msb first, of a fixed byte per slot
        b = {3'h5, nxt[7:3]};
        backplane_rx_data <= b[3'h7 - nxt[2:0]];
        for (int i = 0; i < 4; i++) begin
          b = {1'b1, 2'(i), nxt[7:3]};
          e1_bus_rx[i] <= b[3'h7 - nxt[2:0]];
        end
      end
    end
  end
endmodule // backplane_model

`default_nettype wire

// >>> pcm_fifo.sv
// shared constants and the small word fifo of the pcm timeslot block
`default_nettype none

package pcm_pkg;
  // clocking of the core and of the backplane link
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int BIT_CLK_HZ = 2_048_000;
  localparam int DBL_CLK_HZ = 4_096_000;
  localparam int FRAME_HZ = 8_000;
  // frame layout
  localparam int SLOTS = 32;
  localparam int FRAME_BITS = BIT_CLK_HZ / FRAME_HZ;
  localparam int POS_W = $clog2(FRAME_BITS);
  localparam int BIT_IDX_W = 3;
  localparam int SLOT_W = POS_W - BIT_IDX_W;
  localparam int BYTE_W = 8;
  localparam int E1_BUSES = 4;
  localparam int E1_VOICE = 8;
  localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'hff;
  // fifo in the receive path
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = SLOT_W + BYTE_W;
  // double-rate clock loss time, longest time so rounded down
  localparam int DBL_LOSS_NS = 2000;
  localparam int CORE_NS = 1_000_000_000 / CORE_CLK_HZ;
  localparam logic [7:0] DBL_LOSS = 8'(DBL_LOSS_NS / CORE_NS);
  // strap field layout: address pins, slot switch, config switch
  localparam int ADDR_W = 5;
  localparam int SSW_W = 2;
  localparam int CSW_W = 5;
  localparam int CFG_SSW_LSB = ADDR_W;
  localparam int CFG_CSW_LSB = ADDR_W + SSW_W;
  localparam int CFG_W = CFG_CSW_LSB + CSW_W;
  localparam int STAT_W = ADDR_W + SSW_W;
  localparam int CSW_ALIGN_W = 3;
  // processor port bundle layout
  localparam int CPU_RD_BIT = 0;
  localparam int CPU_WR_BIT = 1;
  localparam int CPU_SEL_BIT = 2;
  localparam int CPU_DAT_LSB = 3;
  localparam int CPU_W = CPU_DAT_LSB + BYTE_W;
  localparam int DIN_W = 2;
  localparam int DOUT_W = 4;
endpackage

`timescale 1ns/10ps

// fifo with valid and ready on both sides
module pcm_fifo #(
  parameter int W = 13,
  parameter int D = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // word storage
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // words held
  } fifo_st_t;

  fifo_st_t cur, nxt;
  logic push, pop;

  // full refuses, empty withholds
  assign in_ready = (cur.cnt != (AW+1)'(D));
  assign out_valid = (cur.cnt != '0);
  assign out_data = cur.mem[cur.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    nxt = cur;
    if (push) begin
      nxt.mem[cur.wp] = in_data;
      nxt.wp = (cur.wp == AW'(D-1)) ? '0 : cur.wp + 1'b1;
    end
    if (pop) begin
      nxt.rp = (cur.rp == AW'(D-1)) ? '0 : cur.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt.cnt = cur.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt.cnt = cur.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  fifo_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (push && !pop) |=> cur.cnt == $past(cur.cnt) + 1'b1)
    else $error("fifo count did not grow on push");
  fifo_full_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cur.cnt <= (AW+1)'(D))
    else $error("fifo count beyond depth");
endmodule // pcm_fifo

`default_nettype wire

// >>> pcm_timeslot.sv
// backplane pcm timeslot interface with time-switch matrix
`default_nettype none
`timescale 1ns/10ps

// How it works
// - 32 slots per frame at 2.048 MHz
// - drive 8 kHz frame sync at frame start
// - receive all 32 slots every frame
// - transmit organised as 32 slots per frame
// - transmit buffer enabled only in transmission phase
// - enable transmit only in assigned segment
// - seven strap inputs configure slot assignment
// - processor can read address pins and switch
// - config switch selects mode, aligns frame sync
// - backplane receive feeds matrix main input
// - matrix main output drives backplane transmit
// - four internal 2.048 MHz e1 buses generated
// - bus n uses matrix input/output n
// - two input buffers, four output flops
module pcm_timeslot
  import pcm_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // backplane clocks, sampled by core_clk
  input wire logic bit_clock_2m,
  input wire logic double_rate_clock,
  // backplane pcm highway
  input wire logic backplane_rx_data,
  output logic backplane_tx_data,
  output logic backplane_tx_oe,
  output logic frame_sync_8k,
  // internal e1 buses, bit n-1 is bus n
  input wire logic [E1_BUSES-1:0] e1_bus_rx,
  output logic [E1_BUSES-1:0] e1_bus_tx,
  // straps
  input wire logic [ADDR_W-1:0] addr_pins,
  input wire logic [SSW_W-1:0] slot_select_switch,
  input wire logic [CSW_W-1:0] config_select_switch,
  output logic [STAT_W-1:0] config_status,
  output logic [CSW_W-1:0] config_mode,
  // processor digital i/o port
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_sel,
  input wire logic [BYTE_W-1:0] cpu_data_in,
  output logic [BYTE_W-1:0] cpu_data_out,
  output logic cpu_data_oe,
  input wire logic [DIN_W-1:0] digital_in,
  output logic [DOUT_W-1:0] digital_out,
  // health
  output logic rx_overrun,
  output logic clocks_ok
);

  typedef struct packed {
    // synchronisers, first stage feeds only second
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_d; // previous bit clock level
    logic dclk_s1;
    logic dclk_s2;
    logic dclk_d; // previous double clock level
    logic [E1_BUSES:0] rx_s1; // bit 0 main, above e1
    logic [E1_BUSES:0] rx_s2;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [CPU_W-1:0] cpu_s1;
    logic [CPU_W-1:0] cpu_s2;
    logic cpu_wd; // previous write strobe
    logic [DIN_W-1:0] din_s1;
    logic [DIN_W-1:0] din_s2;
    // frame position, slot and bit
    logic [POS_W-1:0] pos;
    // receive shifters, one per matrix input
    logic [E1_BUSES:0][BYTE_W-1:0] shift;
    // matrix memories
    logic [SLOTS-1:0][BYTE_W-1:0] main_mem; // from backplane
    logic [SLOTS-1:0][BYTE_W-1:0] e1_mem; // from e1 buses
    logic started; // first frame completed
    logic [7:0] dbl_age; // cycles since double clock edge
    // registered outputs
    logic tx;
    logic oe;
    logic fs;
    logic [E1_BUSES-1:0] e1tx;
    logic [STAT_W-1:0] cfg_stat;
    logic [CSW_W-1:0] cfg_mode;
    logic [BYTE_W-1:0] cpu_out;
    logic cpu_oe;
    logic [DOUT_W-1:0] dout;
    logic overrun;
    logic clk_ok;
  } st_t;

  st_t cur, nxt;

  // edges of the sampled bit clock
  logic b_rise, b_fall;
  assign b_rise = cur.bclk_s2 && !cur.bclk_d;
  assign b_fall = !cur.bclk_s2 && cur.bclk_d;

  // current and next frame position split
  logic [POS_W-1:0] pos_inc;
  logic [SLOT_W-1:0] cslot, nslot;
  logic [BIT_IDX_W-1:0] nbit;
  assign pos_inc = cur.pos + 1'b1;
  assign cslot = cur.pos[POS_W-1:BIT_IDX_W];
  assign nslot = pos_inc[POS_W-1:BIT_IDX_W];
  assign nbit = pos_inc[BIT_IDX_W-1:0];

  // e1 voice slots start at one; slot zero wraps out of range
  logic [SLOT_W-1:0] c_voice, n_voice;
  assign c_voice = cslot - 1'b1;
  assign n_voice = nslot - 1'b1;

  // a whole byte arrives on the rising edge of bit seven
  logic byte_done, e1_wr;
  assign byte_done = b_rise && (cur.pos[BIT_IDX_W-1:0] == '1);
  assign e1_wr = byte_done && (c_voice < SLOT_W'(E1_VOICE));

  // strap fields after synchronising
  logic [ADDR_W-1:0] seg_start;
  logic [SSW_W-1:0] seg_code;
  logic [CSW_ALIGN_W-1:0] align;
  assign seg_start = cur.cfg_s2[ADDR_W-1:0];
  assign seg_code = cur.cfg_s2[CFG_SSW_LSB +: SSW_W];
  assign align = cur.cfg_s2[CFG_CSW_LSB +: CSW_ALIGN_W];

  // segment starts at the address pins, 1, 2, 4 or 8 slots long
  logic [SLOT_W:0] seg_len;
  logic [SLOT_W-1:0] n_rel, c_rel;
  assign seg_len = (SLOT_W+1)'(1) << seg_code;
  assign n_rel = nslot - seg_start;
  assign c_rel = cslot - seg_start;

  // sync moved earlier by the align bits of the config switch
  logic [POS_W-1:0] fs_at;
  assign fs_at = POS_W'(0) - POS_W'(align);

  // receive fifo: main bytes tagged with their slot
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [FIFO_W-1:0] f_in_data, f_out_data;
  assign f_in_data = {cslot, cur.shift[0][BYTE_W-2:0], cur.rx_s2[0]};
  // drain stalls while the e1 byte takes the write cycle
  assign f_out_ready = !e1_wr;

  pcm_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(byte_done),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // matrix output bits toward the e1 buses, one per bus
  logic [E1_BUSES-1:0] e1_bit;
  generate
    for (genvar n = 0; n < E1_BUSES; n++) begin : g_e1
      // voice slots carry backplane bytes, others idle
      assign e1_bit[n] = (n_voice < SLOT_W'(E1_VOICE)) ?
        cur.main_mem[{2'(n), n_voice[BIT_IDX_W-1:0]}][~nbit] :
        IDLE_BYTE[~nbit];
    end
  endgenerate

  // next state of the whole block
  always_comb begin
    nxt = cur;
    // two-flop synchronisers for every pin
    nxt.bclk_s1 = bit_clock_2m;
    nxt.bclk_s2 = cur.bclk_s1;
    nxt.bclk_d = cur.bclk_s2;
    nxt.dclk_s1 = double_rate_clock;
    nxt.dclk_s2 = cur.dclk_s1;
    nxt.dclk_d = cur.dclk_s2;
    nxt.rx_s1 = {e1_bus_rx, backplane_rx_data};
    nxt.rx_s2 = cur.rx_s1;
    nxt.cfg_s1 = {config_select_switch, slot_select_switch, addr_pins};
    nxt.cfg_s2 = cur.cfg_s1;
    nxt.cpu_s1 = {cpu_data_in, cpu_sel, cpu_wr, cpu_rd};
    nxt.cpu_s2 = cur.cpu_s1;
    nxt.din_s1 = digital_in;
    nxt.din_s2 = cur.din_s1;

    // double-rate clock watchdog, saturating age
    if (cur.dclk_s2 != cur.dclk_d) begin
      nxt.dbl_age = '0;
    end else if (cur.dbl_age != DBL_LOSS) begin
      nxt.dbl_age = cur.dbl_age + 8'h01;
    end
    nxt.clk_ok = (nxt.dbl_age != DBL_LOSS);

    // sample all matrix inputs on the rising edge
    if (b_rise) begin
      for (int i = 0; i <= E1_BUSES; i++) begin
        nxt.shift[i] = {cur.shift[i][BYTE_W-2:0], cur.rx_s2[i]};
      end
    end
    // e1 voice bytes land straight in their slot
    if (e1_wr) begin
      for (int i = 0; i < E1_BUSES; i++) begin
        nxt.e1_mem[{2'(i), c_voice[BIT_IDX_W-1:0]}] =
          {cur.shift[i+1][BYTE_W-2:0], cur.rx_s2[i+1]};
      end
    end
    // backplane bytes reach the matrix through the fifo
    if (f_out_valid && f_out_ready) begin
      nxt.main_mem[f_out_data[FIFO_W-1:BYTE_W]] =
        f_out_data[BYTE_W-1:0];
    end
    // a byte refused by a full fifo is lost, flag it
    if (byte_done && !f_in_ready) begin
      nxt.overrun = 1'b1;
    end

    // new bit position and outputs on the falling edge
    if (b_fall) begin
      nxt.pos = pos_inc;
      if (pos_inc == '0) begin
        nxt.started = 1'b1;
      end
      nxt.fs = (pos_inc == fs_at);
      nxt.oe = nxt.started && ({1'b0, n_rel} < seg_len);
      // slot s carries bus s/8+1, voice slot s%8+1
      nxt.tx = cur.e1_mem[nslot][~nbit];
      nxt.e1tx = e1_bit;
    end
    // no transmit phase while the timing clock is lost
    if (!nxt.clk_ok) begin
      nxt.oe = 1'b0;
    end
    // line data held low whenever the buffer is off
    if (!nxt.oe) begin
      nxt.tx = 1'b0;
    end

    // strap readback and mode bits
    nxt.cfg_stat = cur.cfg_s2[STAT_W-1:0];
    nxt.cfg_mode = cur.cfg_s2[CFG_CSW_LSB +: CSW_W];

    // processor port: read drives the data bus
    nxt.cpu_oe = cur.cpu_s2[CPU_RD_BIT];
    if (cur.cpu_s2[CPU_SEL_BIT]) begin
      nxt.cpu_out = {1'b0, nxt.cfg_stat};
    end else begin
      nxt.cpu_out = {(BYTE_W-DIN_W)'(0), cur.din_s2};
    end
    // write latches the low nibble on the strobe edge
    nxt.cpu_wd = cur.cpu_s2[CPU_WR_BIT];
    if (cur.cpu_s2[CPU_WR_BIT] && !cur.cpu_wd) begin
      nxt.dout = cur.cpu_s2[CPU_DAT_LSB +: DOUT_W];
    end
  end

  // state register; all outputs come from here
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from flops
  assign backplane_tx_data = cur.tx;
  assign backplane_tx_oe = cur.oe;
  assign frame_sync_8k = cur.fs;
  assign e1_bus_tx = cur.e1tx;
  assign config_status = cur.cfg_stat;
  assign config_mode = cur.cfg_mode;
  assign cpu_data_out = cur.cpu_out;
  assign cpu_data_oe = cur.cpu_oe;
  assign digital_out = cur.dout;
  assign rx_overrun = cur.overrun;
  assign clocks_ok = cur.clk_ok;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence wr_edge;
    cur.cpu_s2[CPU_WR_BIT] && !cur.cpu_wd;
  endsequence

  sequence frame_end;
    b_fall && (cur.pos == '1);
  endsequence

  // enable just set at a bit boundary, straps unchanged since then;
  // a strap change inside a bit only takes hold at the next boundary
  sequence seg_update;
    b_fall ##1 (backplane_tx_oe && $stable(cur.cfg_s2));
  endsequence

  fs_place_a: assert property (
    frame_sync_8k |-> cur.pos == fs_at)
    else $error("frame sync away from frame start");
  oe_segment_a: assert property (
    seg_update |-> ({1'b0, c_rel} < seg_len))
    else $error("transmit enabled outside segment");
  oe_phase_a: assert property (
    backplane_tx_oe |-> (cur.started && clocks_ok))
    else $error("transmit enabled outside transmission phase");
  tx_quiet_a: assert property (
    !backplane_tx_oe |-> !backplane_tx_data)
    else $error("transmit data active while buffer off");
  pos_wrap_a: assert property (
    frame_end |=> (cur.pos == '0) && cur.started)
    else $error("position did not restart at frame end");
  pos_hold_a: assert property (
    !b_fall |=> $stable(cur.pos))
    else $error("position moved without bit clock edge");
  // read data was formed from the select of the cycle before
  cfg_read_a: assert property (
    (cpu_data_oe && $past(cur.cpu_s2[CPU_SEL_BIT]) && $stable(config_status))
      |-> cpu_data_out == {1'b0, config_status})
    else $error("strap readback mismatch");
  dout_write_a: assert property (
    wr_edge |=> digital_out == $past(cur.cpu_s2[CPU_DAT_LSB +: DOUT_W]))
    else $error("digital output not latched on write");
  e1_idle_a: assert property (
    (b_fall && n_voice >= SLOT_W'(E1_VOICE)) |=> e1_bus_tx == '1)
    else $error("e1 bus not idle outside voice slots");
  fs_edge_a: assert property (
    $rose(frame_sync_8k) |-> $past(b_fall))
    else $error("frame sync rose without bit clock edge");
  overrun_hold_a: assert property (
    rx_overrun |=> rx_overrun)
    else $error("overrun flag dropped without reset");
  phase_hold_a: assert property (
    cur.started |=> cur.started)
    else $error("transmission phase fell back before reset");
endmodule // pcm_timeslot

`default_nettype wire

// >>> tb_pcm_timeslot.sv
// self-checking bench of the pcm timeslot block and its word fifo
`timescale 1ns/10ps
`default_nettype none

module tb_pcm_timeslot
  import pcm_pkg::*;
;
  logic core_clk, sys_rst, run, dbl_stop; // clock, reset, model controls
  logic bclk, dclk, rxd, txd, txoe, fs; // backplane highway
  logic [3:0] e1_rx, e1_tx, digital_out; // e1 buses, output flops
  logic [4:0] addr_pins, config_select_switch, config_mode; // straps
  logic [1:0] slot_select_switch, digital_in;
  logic [6:0] config_status;
  logic cpu_rd, cpu_wr, cpu_sel, cpu_data_oe, rx_overrun, clocks_ok;
  logic [7:0] cpu_data_in, cpu_data_out;
  int error_cnt = 0, samples_checked = 0, cycles = 0;

  pcm_timeslot i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .bit_clock_2m(bclk), .double_rate_clock(dclk),
    .backplane_rx_data(rxd), .backplane_tx_data(txd),
    .backplane_tx_oe(txoe), .frame_sync_8k(fs), .e1_bus_rx(e1_rx),
    .e1_bus_tx(e1_tx), .addr_pins(addr_pins),
    .slot_select_switch(slot_select_switch),
    .config_select_switch(config_select_switch),
    .config_status(config_status), .config_mode(config_mode),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_sel(cpu_sel),
    .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out),
    .cpu_data_oe(cpu_data_oe), .digital_in(digital_in),
    .digital_out(digital_out), .rx_overrun(rx_overrun),
    .clocks_ok(clocks_ok));
  backplane_model i_bp (.core_clk(core_clk), .run(run), .dbl_stop(dbl_stop),
    .bit_clock_2m(bclk), .double_rate_clock(dclk),
    .backplane_rx_data(rxd), .e1_bus_rx(e1_rx), .backplane_tx_data(txd),
    .backplane_tx_oe(txoe), .frame_sync_8k(fs), .e1_bus_tx(e1_tx));

  always #50 core_clk = ~core_clk;

  // hang guard, well above the roughly 33000 cycles of the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 32'h0000c350) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // wait n edges, then let that edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic frm(input int n);
    int f;
    f = i_bp.frames;
    wait (i_bp.frames >= f + n);
  endtask

  task automatic t_straps();
    cyc(6);
    chk("status", 16'h0023, 16'(config_status));
    chk("mode", 16'h0018, 16'(config_mode));
  endtask

  task automatic t_cpu();
    @(posedge core_clk);
    cpu_data_in <= 8'h0a;
    cpu_wr <= 1'b1;
    digital_in <= 2'h2;
    cyc(4);
    chk("digital out", 16'h000a, 16'(digital_out));
    @(posedge core_clk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b1;
    cyc(4);
    chk("read enable", 16'h0001, 16'(cpu_data_oe));
    chk("digital in", 16'h0002, 16'(cpu_data_out[1:0]));
    @(posedge core_clk);
    cpu_sel <= 1'b1;
    cyc(4);
    chk("strap read", 16'h0023, 16'(cpu_data_out[6:0]));
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    cyc(4);
    chk("read released", 16'h0000, 16'(cpu_data_oe));
  endtask

  // receive fifo seen inside the block: one slot-tagged byte per slot;
  // the first sync only lines the model up, the second frame is judged
  task automatic t_fifo();
    int k, w;
    repeat (2) @(posedge fs);
    k = 0;
    w = 0;
    repeat (2048) begin
      cyc(1);
      if (i_dut.u_rx_fifo.in_valid && i_dut.u_rx_fifo.in_ready) w++;
      if (i_dut.u_rx_fifo.out_valid && i_dut.u_rx_fifo.out_ready) begin
        chk("fifo word", {3'h0, 5'(k), 3'h5, 5'(k)},
            16'(i_dut.u_rx_fifo.out_data));
        k++;
      end
    end
    chk("fifo words taken", 16'h0020, 16'(w));
    chk("fifo words out", 16'h0020, 16'(k));
    chk("fifo empty", 16'h0000, 16'(i_dut.u_rx_fifo.out_valid));
  endtask

  task automatic t_sync();
    int h, r;
    logic l;
    h = 0;
    l = 1'b1;
    @(posedge fs);
    for (int c = 1; c <= 2048; c++) begin
      cyc(1);
      if (fs === 1'b1) h++;
      if (fs === 1'b1 && !l) r = c;
      l = fs;
    end
    chk("sync high cycles", 16'h0008, 16'(h));
    chk("sync period", 16'h0800, 16'(r));
  endtask

  task automatic t_seg(input logic [4:0] a, input logic [1:0] s);
    logic [7:0] tb_b;
    logic [7:0] eb [4];
    logic [4:0] sl;
    logic inseg;
    @(posedge core_clk);
    addr_pins <= a;
    slot_select_switch <= s;
    frm(3);
    for (int p = 0; p < 256; p++) begin
      sl = 5'(p >> 3);
      inseg = int'(5'(sl - a)) < (1 << s);
      chk("tx enable", 16'(inseg), 16'(i_bp.oeb[p]));
      tb_b[7 - p % 8] = i_bp.txb[p];
      for (int i = 0; i < 4; i++) eb[i][7 - p % 8] = i_bp.e1b[p][i];
      if (p % 8 == 7) begin
        if (inseg)
          chk("tx byte", {1'b1, sl[4:3], 5'({2'h0, sl[2:0]} + 5'h01)},
              16'(tb_b));
        else chk("idle tx byte", 16'h0000, 16'(tb_b));
        for (int i = 0; i < 4; i++)
          chk("e1 byte", (sl >= 5'h01 && sl <= 5'h08) ?
              {3'h5, 2'(i), 3'(sl - 5'h01)} : IDLE_BYTE,
              16'(eb[i]));
      end
    end
    chk("overrun", 16'h0000, 16'(rx_overrun));
  endtask

  // cycles from sync to enable: 8 per bit before slot 3, plus 8 per bit of advance
  task automatic t_align(input logic [2:0] adv, input logic [15:0] exp);
    int n;
    @(posedge core_clk);
    addr_pins <= 5'h03;
    slot_select_switch <= 2'h1;
    config_select_switch <= {2'h3, adv};
    frm(2);
    @(posedge fs);
    n = 0;
    while (txoe !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk("sync to enable", exp, 16'(n));
  endtask

  task automatic t_loss();
    chk("clocks alive", 16'h0001, 16'(clocks_ok));
    @(posedge core_clk);
    dbl_stop <= 1'b1;
    cyc(30);
    chk("clock loss flag", 16'h0000, 16'(clocks_ok));
    chk("enable on loss", 16'h0000, 16'(txoe));
    @(posedge core_clk);
    dbl_stop <= 1'b0;
    cyc(10);
    chk("clocks back", 16'h0001, 16'(clocks_ok));
  endtask

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {run, dbl_stop, cpu_rd, cpu_wr, cpu_sel} = 5'h00;
    addr_pins = 5'h03;
    slot_select_switch = 2'h1;
    config_select_switch = 5'h18;
    cpu_data_in = 8'h00;
    digital_in = 2'h0;
    cyc(2);
    chk("enable in reset", 16'h0000, 16'(txoe));
    chk("flops in reset", 16'h0000, {fs, digital_out, rx_overrun});
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    run <= 1'b1;
    t_straps();
    t_cpu();
    t_fifo();
    t_sync();
    t_seg(5'h03, 2'h1);
    t_seg(5'h1e, 2'h3);
    t_align(3'h0, 16'h00c0);
    t_align(3'h3, 16'h00d8);
    t_loss();
    test_done();
  end
endmodule // tb_pcm_timeslot

`default_nettype wire
